// file: logic/bsp_pkg.sv
// Constants and state types shared by the buffered serial port pin logic
package bsp_pkg;

   // Port count, word size and buffering
   localparam int BSP_NPORT = 3;
   localparam int BSP_WORD_W = 16;
   localparam int BSP_FIFO_DEPTH = 16;

   // Clock rates and the divider for a locally generated shift clock
   localparam int BSP_MCLK_PERIOD_NS = 40;
   localparam int BSP_LINK_PERIOD_NS = 160;
   localparam int BSP_CLK_DIV = BSP_LINK_PERIOD_NS / (2 * BSP_MCLK_PERIOD_NS);
   localparam int BSP_DIV_W = 4;

   // Shift clock periods between locally generated receive frame pulses
   localparam int BSP_RX_FRAME_BITS = 32;
   localparam int BSP_RX_FRAME_W = 6;

   // Transmit sequencer, Gray coded along idle, shift, tail
   typedef enum logic [1:0]
   {
      BSP_TX_IDLE = 2'h0,
      BSP_TX_SHIFT = 2'h1,
      BSP_TX_TAIL = 2'h3
   } bsp_tx_state_e;

   // Receive sequencer
   typedef enum logic
   {
      BSP_RX_IDLE = 1'h0,
      BSP_RX_SHIFT = 1'h1
   } bsp_rx_state_e;

endpackage : bsp_pkg

// file: logic/bsp_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module bsp_fifo
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];

   // Occupancy after this cycle's push and pop
   always_comb
   begin
      next_count = count;
      if (push && !pop)
      begin
         next_count = count + 1'b1;
      end
      else if (pop && !push)
      begin
         next_count = count - 1'b1;
      end
   end

   // Pointers, count and registered not-full flag
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_o <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= next_count;
         in_ready_o <= (next_count != CNT_W'(DEPTH));
      end
   end

   // Storage
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data_i;
      end
   end

endmodule : bsp_fifo

// file: logic/bsp_port.sv
// Three buffered serial ports: pin directions, floating and word shifting
`timescale 1ns/1ns
module bsp_port
   import bsp_pkg::*;
#(
   parameter int NPORT = BSP_NPORT,
   parameter int WORD_W = BSP_WORD_W,
   parameter int FIFO_DEPTH = BSP_FIFO_DEPTH
)
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic out_float_n_i,
   input wire logic [NPORT-1:0] rx_clk_out_en_i,
   input wire logic [NPORT-1:0] rx_frame_out_en_i,
   input wire logic [NPORT-1:0] tx_clk_out_en_i,
   input wire logic [NPORT-1:0] tx_frame_out_en_i,
   input wire logic [NPORT-1:0] rx_shift_clk_i,
   output wire logic [NPORT-1:0] rx_shift_clk_o,
   output wire logic [NPORT-1:0] rx_shift_clk_oe_o,
   input wire logic [NPORT-1:0] rx_serial_in_i,
   input wire logic [NPORT-1:0] rx_frame_pulse_i,
   output wire logic [NPORT-1:0] rx_frame_pulse_o,
   output wire logic [NPORT-1:0] rx_frame_pulse_oe_o,
   input wire logic [NPORT-1:0] tx_shift_clk_i,
   output wire logic [NPORT-1:0] tx_shift_clk_o,
   output wire logic [NPORT-1:0] tx_shift_clk_oe_o,
   output wire logic [NPORT-1:0] tx_serial_out_o,
   output wire logic [NPORT-1:0] tx_serial_out_oe_o,
   input wire logic [NPORT-1:0] tx_frame_pulse_i,
   output wire logic [NPORT-1:0] tx_frame_pulse_o,
   output wire logic [NPORT-1:0] tx_frame_pulse_oe_o,
   input wire logic [NPORT-1:0][WORD_W-1:0] tx_word_i,
   input wire logic [NPORT-1:0] tx_valid_i,
   output wire logic [NPORT-1:0] tx_ready_o,
   output wire logic [NPORT-1:0][WORD_W-1:0] rx_word_o,
   output wire logic [NPORT-1:0] rx_valid_o
);
   localparam int CNT_W = $clog2(WORD_W + 1);

   logic float_s1;
   logic float_s2;
   logic [BSP_DIV_W-1:0] div_cnt;
   logic gen_clk;

   // Output-float pin into the system clock domain
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         float_s1 <= 1'b0;
         float_s2 <= 1'b0;
      end
      else
      begin
         float_s1 <= out_float_n_i;
         float_s2 <= float_s1;
      end
   end

   // Shift clock source for pins set to drive their clock
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         div_cnt <= '0;
         gen_clk <= 1'b0;
      end
      else if (div_cnt == BSP_DIV_W'(BSP_CLK_DIV - 1))
      begin
         div_cnt <= '0;
         gen_clk <= ~gen_clk;
      end
      else
      begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // One independent port per pass
   for (genvar g = 0; g < NPORT; g++)
   begin : g_port
      logic rx_clk_oe;
      logic rx_frm_oe;
      logic tx_clk_oe;
      logic tx_frm_oe;
      logic tx_dat_oe;
      logic tx_rst_s1;
      logic tx_rst_s2;
      logic rx_rst_s1;
      logic rx_rst_s2;
      bsp_tx_state_e tx_state;
      logic [CNT_W-1:0] tx_cnt;
      logic [WORD_W-1:0] tx_sh;
      logic [WORD_W-1:0] tx_hold;
      logic tx_bit;
      logic tx_fgen;
      logic tx_req;
      logic tx_ack;
      logic treq_s1;
      logic treq_s2;
      logic tack_s1;
      logic tack_s2;
      logic busy_s1;
      logic busy_s2;
      logic tx_pend;
      logic fifo_valid;
      logic fifo_pop;
      logic [WORD_W-1:0] fifo_data;
      bsp_rx_state_e rx_state;
      logic [CNT_W-1:0] rx_cnt;
      logic [WORD_W-1:0] rx_sh;
      logic [WORD_W-1:0] rx_hold;
      logic rx_tog;
      logic [BSP_RX_FRAME_W-1:0] rx_fcnt;
      logic rx_fgen;
      logic rtog_s1;
      logic rtog_s2;
      logic rtog_s3;
      logic [WORD_W-1:0] rx_word;
      logic rx_valid;

      // Pin drive enables: inputs until configured, floated on request
      always_ff @(posedge mclk_i)
      begin
         if (!rst_n_i)
         begin
            rx_clk_oe <= 1'b0;
            rx_frm_oe <= 1'b0;
            tx_clk_oe <= 1'b0;
            tx_frm_oe <= 1'b0;
            tx_dat_oe <= 1'b0;
         end
         else
         begin
            rx_clk_oe <= rx_clk_out_en_i[g] && float_s2;
            rx_frm_oe <= rx_frame_out_en_i[g] && float_s2;
            tx_clk_oe <= tx_clk_out_en_i[g] && float_s2;
            tx_frm_oe <= tx_frame_out_en_i[g] && float_s2;
            tx_dat_oe <= busy_s2 && float_s2;
         end
      end

      assign rx_shift_clk_o[g] = gen_clk;
      assign rx_shift_clk_oe_o[g] = rx_clk_oe;
      assign rx_frame_pulse_o[g] = rx_fgen;
      assign rx_frame_pulse_oe_o[g] = rx_frm_oe;
      assign tx_shift_clk_o[g] = gen_clk;
      assign tx_shift_clk_oe_o[g] = tx_clk_oe;
      assign tx_serial_out_o[g] = tx_bit;
      assign tx_serial_out_oe_o[g] = tx_dat_oe;
      assign tx_frame_pulse_o[g] = tx_fgen;
      assign tx_frame_pulse_oe_o[g] = tx_frm_oe;
      assign rx_word_o[g] = rx_word;
      assign rx_valid_o[g] = rx_valid;

      // Transmit words wait here for their frame
      bsp_fifo #(
         .WIDTH(WORD_W),
         .DEPTH(FIFO_DEPTH)
      ) u_tx_fifo (
         .clk_i(mclk_i),
         .rst_n_i(rst_n_i),
         .in_valid_i(tx_valid_i[g]),
         .in_ready_o(tx_ready_o[g]),
         .in_data_i(tx_word_i[g]),
         .out_valid_o(fifo_valid),
         .out_ready_i(fifo_pop),
         .out_data_o(fifo_data)
      );

      // Hand one word at a time to the transmit clock domain
      assign fifo_pop = fifo_valid && (tx_req == tack_s2);

      always_ff @(posedge mclk_i)
      begin
         if (!rst_n_i)
         begin
            tx_req <= 1'b0;
            tx_hold <= '0;
         end
         else if (fifo_pop)
         begin
            tx_req <= ~tx_req;
            tx_hold <= fifo_data;
         end
      end

      // Acknowledge and busy back into the system clock domain
      always_ff @(posedge mclk_i)
      begin
         if (!rst_n_i)
         begin
            tack_s1 <= 1'b0;
            tack_s2 <= 1'b0;
            busy_s1 <= 1'b0;
            busy_s2 <= 1'b0;
         end
         else
         begin
            tack_s1 <= tx_ack;
            tack_s2 <= tack_s1;
            busy_s1 <= tx_state[0]; // Low only when idle
            busy_s2 <= busy_s1;
         end
      end

      // Reset and request into the transmit clock domain
      always_ff @(posedge tx_shift_clk_i[g])
      begin
         tx_rst_s1 <= rst_n_i;
         tx_rst_s2 <= tx_rst_s1;
         treq_s1 <= tx_req;
         treq_s2 <= treq_s1;
      end

      assign tx_pend = (treq_s2 != tx_ack);

      // Transmit sequencer: frame, then one bit per shift clock, MSB first
      always_ff @(posedge tx_shift_clk_i[g])
      begin
         if (!tx_rst_s2)
         begin
            tx_state <= BSP_TX_IDLE;
            tx_cnt <= '0;
            tx_sh <= '0;
            tx_bit <= 1'b0;
            tx_ack <= 1'b0;
         end
         else
         begin
            unique case (tx_state)
               BSP_TX_IDLE:
               begin
                  if (tx_frame_pulse_i[g] && tx_pend)
                  begin
                     tx_sh <= tx_hold;
                     tx_ack <= ~tx_ack;
                     tx_cnt <= '0;
                     tx_state <= BSP_TX_SHIFT;
                  end
               end
               BSP_TX_SHIFT:
               begin
                  tx_bit <= tx_sh[WORD_W-1];
                  tx_sh <= {tx_sh[WORD_W-2:0], 1'b0};
                  tx_cnt <= tx_cnt + 1'b1;
                  if (tx_cnt == CNT_W'(WORD_W - 1))
                  begin
                     tx_state <= BSP_TX_TAIL;
                  end
               end
               BSP_TX_TAIL:
               begin
                  tx_state <= BSP_TX_IDLE; // Last bit held a full period
               end
               default:
               begin
                  tx_state <= BSP_TX_IDLE;
               end
            endcase
         end
      end

      // Local transmit frame pulse, one period, when a word waits
      always_ff @(posedge tx_shift_clk_i[g])
      begin
         if (!tx_rst_s2)
         begin
            tx_fgen <= 1'b0;
         end
         else
         begin
            tx_fgen <= (tx_state == BSP_TX_IDLE) && tx_pend && !tx_fgen;
         end
      end

      // Reset into the receive clock domain
      always_ff @(posedge rx_shift_clk_i[g])
      begin
         rx_rst_s1 <= rst_n_i;
         rx_rst_s2 <= rx_rst_s1;
      end

      // Receive sequencer: frame, then one bit per shift clock, MSB first
      always_ff @(posedge rx_shift_clk_i[g])
      begin
         if (!rx_rst_s2)
         begin
            rx_state <= BSP_RX_IDLE;
            rx_cnt <= '0;
            rx_sh <= '0;
            rx_hold <= '0;
            rx_tog <= 1'b0;
         end
         else
         begin
            unique case (rx_state)
               BSP_RX_IDLE:
               begin
                  if (rx_frame_pulse_i[g])
                  begin
                     rx_cnt <= '0;
                     rx_state <= BSP_RX_SHIFT;
                  end
               end
               BSP_RX_SHIFT:
               begin
                  rx_sh <= {rx_sh[WORD_W-2:0], rx_serial_in_i[g]};
                  rx_cnt <= rx_cnt + 1'b1;
                  if (rx_cnt == CNT_W'(WORD_W - 1))
                  begin
                     rx_hold <= {rx_sh[WORD_W-2:0], rx_serial_in_i[g]};
                     rx_tog <= ~rx_tog;
                     rx_state <= BSP_RX_IDLE;
                  end
               end
            endcase
         end
      end

      // Local receive frame pulse, periodic
      always_ff @(posedge rx_shift_clk_i[g])
      begin
         if (!rx_rst_s2)
         begin
            rx_fcnt <= '0;
            rx_fgen <= 1'b0;
         end
         else
         begin
            rx_fgen <= (rx_fcnt == '0);
            if (rx_fcnt == BSP_RX_FRAME_W'(BSP_RX_FRAME_BITS - 1))
            begin
               rx_fcnt <= '0;
            end
            else
            begin
               rx_fcnt <= rx_fcnt + 1'b1;
            end
         end
      end

      // Received word into the system clock domain by toggle
      always_ff @(posedge mclk_i)
      begin
         if (!rst_n_i)
         begin
            rtog_s1 <= 1'b0;
            rtog_s2 <= 1'b0;
            rtog_s3 <= 1'b0;
            rx_word <= '0;
            rx_valid <= 1'b0;
         end
         else
         begin
            rtog_s1 <= rx_tog;
            rtog_s2 <= rtog_s1;
            rtog_s3 <= rtog_s2;
            rx_valid <= rtog_s2 ^ rtog_s3;
            if (rtog_s2 ^ rtog_s3)
            begin
               rx_word <= rx_hold; // Held stable for a whole word time
            end
         end
      end
   end

endmodule : bsp_port

// file: sim/bsp_port_sva.sv
// Checker for pin direction, float and receive pulse behaviour
`timescale 1ns/1ns
module bsp_port_sva
#(
   parameter int NPORT = 3
)
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic out_float_n_i,
   input wire logic [NPORT-1:0] rx_clk_out_en_i,
   input wire logic [NPORT-1:0] rx_frame_out_en_i,
   input wire logic [NPORT-1:0] tx_clk_out_en_i,
   input wire logic [NPORT-1:0] tx_frame_out_en_i,
   input wire logic [NPORT-1:0] rx_shift_clk_oe_o,
   input wire logic [NPORT-1:0] rx_frame_pulse_oe_o,
   input wire logic [NPORT-1:0] tx_shift_clk_oe_o,
   input wire logic [NPORT-1:0] tx_serial_out_oe_o,
   input wire logic [NPORT-1:0] tx_frame_pulse_oe_o,
   input wire logic [NPORT-1:0] rx_valid_o
);
   // One clock domain for all checks
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   // Transmit driver enables as they leave reset
   property p_rst_off;
      $rose(rst_n_i) |-> (tx_serial_out_oe_o | tx_shift_clk_oe_o | tx_frame_pulse_oe_o) == '0;
   endproperty
   a_rst_off: assert property (p_rst_off) else $error("driver on at reset exit");
   property p_rxc_dir;
      out_float_n_i [*4] ##0 $stable(rx_clk_out_en_i) [*2] |-> rx_shift_clk_oe_o == rx_clk_out_en_i;
   endproperty
   a_rxc_dir: assert property (p_rxc_dir) else $error("rx clock direction");
   property p_rxf_dir;
      out_float_n_i [*4] ##0 $stable(rx_frame_out_en_i) [*2] |-> rx_frame_pulse_oe_o == rx_frame_out_en_i;
   endproperty
   a_rxf_dir: assert property (p_rxf_dir) else $error("rx frame direction");
   property p_txc_dir;
      (out_float_n_i && $stable(tx_clk_out_en_i)) [*4] |-> tx_shift_clk_oe_o == tx_clk_out_en_i;
   endproperty
   a_txc_dir: assert property (p_txc_dir) else $error("tx clock direction");
   property p_txf_dir;
      out_float_n_i [*3] ##1 $stable(tx_frame_out_en_i) |-> tx_frame_pulse_oe_o == tx_frame_out_en_i;
   endproperty
   a_txf_dir: assert property (p_txf_dir) else $error("tx frame direction");
   property p_txc_float;
      !out_float_n_i [*4] |-> tx_shift_clk_oe_o == '0;
   endproperty
   a_txc_float: assert property (p_txc_float) else $error("tx clock driven in float");
   property p_txf_float;
      $fell(out_float_n_i) ##1 !out_float_n_i [*2] |=> tx_frame_pulse_oe_o == '0;
   endproperty
   a_txf_float: assert property (p_txf_float) else $error("tx frame driven in float");
   property p_txd_float;
      !out_float_n_i [*3] |=> tx_serial_out_oe_o == '0;
   endproperty
   a_txd_float: assert property (p_txd_float) else $error("tx data driven in float");
   property p_rx_pulse;
      rx_valid_o[0] |=> !rx_valid_o[0];
   endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("rx valid longer than one cycle");

   // Main scenarios reached
   c_rx_word: cover property (rx_valid_o[0]);
   c_float: cover property (!out_float_n_i [*4]);
   c_tx_on: cover property ($rose(tx_serial_out_oe_o[0]));
endmodule : bsp_port_sva

bind bsp_port bsp_port_sva #(.NPORT(NPORT)) u_sva (.mclk_i, .rst_n_i, .out_float_n_i,
   .rx_clk_out_en_i, .rx_frame_out_en_i, .tx_clk_out_en_i, .tx_frame_out_en_i,
   .rx_shift_clk_oe_o, .rx_frame_pulse_oe_o, .tx_shift_clk_oe_o, .tx_serial_out_oe_o,
   .tx_frame_pulse_oe_o, .rx_valid_o);

// file: sim/bsp_peer.sv
// Far-side serial peer: link clock, receive frames and data, transmit capture
`timescale 1ns/1ns
module bsp_peer
(
   input wire logic run_i,
   input wire logic [2:0] tx_data_i,
   input wire logic [2:0] tx_oe_i,
   output logic lclk_o,
   output logic [2:0] rx_frame_o,
   output logic [2:0] rx_data_o,
   output logic [2:0] tx_frame_o
);
   logic run;

   // Link clock, parked low between frames, phase offset from mclk
   initial
   begin
      run = 1'b0;
      lclk_o = 1'b0;
      rx_frame_o = 3'h0;
      rx_data_o = 3'h5;
      tx_frame_o = 3'h0;
      #13;
      forever
      begin
         #80;
         if (run_i || run || lclk_o)
            lclk_o = ~lclk_o;
      end
   end

   // Frame then 16 bits MSB first, driven on falling edges
   task automatic rx_send(input int g, input logic [15:0] w);
      run = 1'b1;
      repeat (4) @(negedge lclk_o);
      rx_frame_o[g] = 1'b1;
      for (int i = 15; i >= 0; i--)
      begin
         @(negedge lclk_o);
         rx_frame_o[g] = 1'b0;
         rx_data_o[g] = w[i];
      end
      @(negedge lclk_o);
      rx_data_o[g] = ~rx_data_o[g]; // Line inverted after the last bit
      run = 1'b0;
   endtask : rx_send

   // Frame, then sample 16 bits on falling edges; a floating line reads unknown
   task automatic tx_take(input int g, output logic [15:0] w);
      run = 1'b1;
      repeat (6) @(negedge lclk_o);
      tx_frame_o[g] = 1'b1;
      @(negedge lclk_o);
      tx_frame_o[g] = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         @(negedge lclk_o);
         w[i] = tx_oe_i[g] ? tx_data_i[g] : 1'bx;
      end
      @(negedge lclk_o); // One more rising edge lets the sequencer close the frame
      run = 1'b0;
   endtask : tx_take
endmodule : bsp_peer

// file: sim/bsp_port_tb.sv
// Self-checking bench for the three buffered serial ports
`timescale 1ns/1ns
module bsp_port_tb;
   logic mclk_i, rst_n_i, out_float_n_i, run_link, lclk;
   logic [2:0] rx_clk_out_en_i, rx_frame_out_en_i, tx_clk_out_en_i, tx_frame_out_en_i;
   logic [2:0] rxc_o, rxc_oe, rxf_o, rxf_oe, txc_o, txc_oe, txd_o, txd_oe, txf_o, txf_oe;
   logic [2:0] rxc_w, rxf_w, txc_w, txf_w, p_rxf, p_rxd, p_txf, tx_valid_i, tx_ready_o, rx_valid_o;
   logic [2:0][15:0] tx_word_i, rx_word_o;
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;

   // Wire levels from both parties' drive
   assign rxc_w = (rxc_oe & rxc_o) | (~rxc_oe & {3{lclk}});
   assign rxf_w = (rxf_oe & rxf_o) | (~rxf_oe & p_rxf);
   assign txc_w = (txc_oe & txc_o) | (~txc_oe & {3{lclk}});
   assign txf_w = (txf_oe & txf_o) | (~txf_oe & p_txf);

   bsp_port u_dut (.mclk_i, .rst_n_i, .out_float_n_i, .rx_clk_out_en_i, .rx_frame_out_en_i,
      .tx_clk_out_en_i, .tx_frame_out_en_i, .rx_shift_clk_i(rxc_w), .rx_shift_clk_o(rxc_o),
      .rx_shift_clk_oe_o(rxc_oe), .rx_serial_in_i(p_rxd), .rx_frame_pulse_i(rxf_w),
      .rx_frame_pulse_o(rxf_o), .rx_frame_pulse_oe_o(rxf_oe), .tx_shift_clk_i(txc_w),
      .tx_shift_clk_o(txc_o), .tx_shift_clk_oe_o(txc_oe), .tx_serial_out_o(txd_o),
      .tx_serial_out_oe_o(txd_oe), .tx_frame_pulse_i(txf_w), .tx_frame_pulse_o(txf_o),
      .tx_frame_pulse_oe_o(txf_oe), .tx_word_i, .tx_valid_i, .tx_ready_o, .rx_word_o, .rx_valid_o);

   bsp_peer u_peer (.run_i(run_link), .tx_data_i(txd_o), .tx_oe_i(txd_oe), .lclk_o(lclk),
      .rx_frame_o(p_rxf), .rx_data_o(p_rxd), .tx_frame_o(p_txf));

   // System clock
   initial
   begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   task automatic report_and_stop();
      if (fail_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // Offer one word from a clock edge, give up after 8 refused cycles
   task automatic push(input int g, input logic [15:0] w, output bit ok);
      int n;
      @(posedge mclk_i);
      tx_word_i[g] <= w;
      tx_valid_i[g] <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk_i);
         ok = tx_ready_o[g];
         n++;
      end
      while (!ok && n < 8);
      tx_valid_i[g] <= 1'b0;
      @(posedge mclk_i);
   endtask : push

   task automatic t_reset_dirs();
      check({rxc_oe, rxf_oe, txc_oe, txf_oe, txd_oe}, 16'h0000);
      check(tx_ready_o, 16'h0007);
   endtask : t_reset_dirs

   // A word on each port's receiver
   task automatic t_rx();
      logic [15:0] w;
      for (int g = 0; g < 3; g++)
      begin
         w = 16'h8e71 ^ 16'(g);
         fork
            u_peer.rx_send(g, w);
            for (int n = 0; n < 300 && rx_valid_o[g] !== 1'b1; n++)
               @(posedge mclk_i);
         join
         check(rx_word_o[g], w);
      end
   endtask : t_rx

   // Fill the port 0 buffer until refused, drain it, then an empty frame
   task automatic t_fill_drain();
      bit ok;
      int n;
      logic [15:0] got;
      n = 0;
      ok = 1'b1;
      while (ok && n < 20)
      begin
         push(0, 16'h5a00 + 16'(n), ok);
         if (ok)
            n++;
      end
      check(tx_ready_o[0], 16'h0000);
      check(16'(n >= 16), 16'h0001);
      for (int i = 0; i < n; i++)
      begin
         u_peer.tx_take(0, got);
         check(got, 16'h5a00 + 16'(i));
      end
      u_peer.tx_take(0, got);
      check(got, 16'hxxxx);
      for (int g = 1; g < 3; g++)
      begin
         push(g, 16'hc003 ^ 16'(g), ok);
         u_peer.tx_take(g, got);
         check(got, 16'hc003 ^ 16'(g));
      end
      repeat (8) @(posedge mclk_i);
      check(txd_oe, 16'h0000);
   endtask : t_fill_drain

   // Float all drivers, then release with every clock and frame pin set as output
   task automatic t_float();
      rx_clk_out_en_i <= 3'h7;
      rx_frame_out_en_i <= 3'h7;
      tx_clk_out_en_i <= 3'h7;
      tx_frame_out_en_i <= 3'h7;
      out_float_n_i <= 1'b0;
      repeat (5) @(posedge mclk_i);
      check({rxc_oe, rxf_oe, txc_oe, txf_oe, txd_oe}, 16'h0000);
      out_float_n_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      check({rxc_oe, rxf_oe, txc_oe, txf_oe}, 16'h0fff);
      check(txd_oe, 16'h0000);
   endtask : t_float

   // Port 0 on its own clocks and frames: one word out, a zero word in
   task automatic t_gen();
      bit ok;
      int n;
      logic [15:0] got;
      push(0, 16'h3c96, ok);
      n = 0;
      while (txd_oe[0] !== 1'b1 && n < 200)
      begin
         @(posedge mclk_i);
         n++;
      end
      for (int i = 15; i >= 0; i--)
      begin
         @(negedge txc_o[0]);
         got[i] = txd_oe[0] ? txd_o[0] : 1'bx;
      end
      check(got, 16'h3c96);
      n = 0;
      while (rx_valid_o[0] !== 1'b1 && n < 300)
      begin
         @(posedge mclk_i);
         n++;
      end
      check(rx_word_o[0], 16'h0000);
   endtask : t_gen

   // Cycle ceiling against hangs
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   // Main sequence
   initial
   begin
      rst_n_i = 1'b0;
      out_float_n_i = 1'b1;
      run_link = 1'b1;
      rx_clk_out_en_i = 3'h0;
      rx_frame_out_en_i = 3'h0;
      tx_clk_out_en_i = 3'h0;
      tx_frame_out_en_i = 3'h0;
      tx_word_i = '0;
      tx_valid_i = 3'h0;
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      run_link <= 1'b0;
      repeat (4) @(posedge mclk_i);
      t_reset_dirs();
      t_rx();
      t_fill_drain();
      t_float();
      t_gen();
      report_and_stop();
   end
endmodule : bsp_port_tb
